// ===== core/slw_pkg.sv
// Package for the serial link watchdog and parameter lock block.
// Assumes a 100 MHz mclk; all users reference items as slw_pkg::name.
package slw_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] ADDR_LINK = 5'h00; // node addr, baud, protocol
    localparam logic [4:0] ADDR_WDOG = 5'h04; // watchdog limit and action
    localparam logic [4:0] ADDR_CTRLW = 5'h08; // control word telegram
    localparam logic [4:0] ADDR_LOCK = 5'h0c; // lock setting
    localparam logic [4:0] ADDR_CODE = 5'h10; // stored access code
    localparam logic [4:0] ADDR_ENTRY = 5'h14; // access entry
    localparam logic [4:0] ADDR_STAT = 5'h18; // status, write 1 to clear
    localparam logic [4:0] ADDR_MASK = 5'h1c; // interrupt mask
    // Link register fields
    localparam int ADDR_LSB = 0; // node address bits 5:0
    localparam int BAUD_LSB = 8; // baud select bits 10:8
    localparam int PROT_BIT = 16; // protocol enable
    // Watchdog register fields
    localparam int WSEL_LSB = 0; // limit select bits 2:0
    localparam int WACT_BIT = 4; // 0 trip, 1 coast
    // Status bits
    localparam int ST_TRIP = 0;
    localparam int ST_COAST = 1;
    localparam int ST_REJ = 2;
    localparam int ST_TELEG = 3;
    // Reset values
    localparam logic [31:0] LINK_RST = 32'h0000_0000;
    localparam logic [31:0] WDOG_RST = 32'h0000_0000;
    localparam logic [15:0] CODE_RST = 16'h0065; // 101
    localparam logic [2:0] BAUD_MAX = 3'h4; // 9.6,19.2,38.4,57.6,115.2
    // Timeouts in ms and cycle counts at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int T30_MS = 30;
    localparam int T100_MS = 100;
    localparam int T1000_MS = 1000;
    localparam int T3000_MS = 3000;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam logic [31:0] T30_CYC = 32'(T30_MS * CYC_PER_MS);
    localparam logic [31:0] T100_CYC = 32'(T100_MS * CYC_PER_MS);
    localparam logic [31:0] T1000_CYC = 32'(T1000_MS * CYC_PER_MS);
    localparam logic [31:0] T3000_CYC = 32'(T3000_MS * CYC_PER_MS);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } slw_wd_e;
endpackage

// ===== core/slw_watchdog.sv
// Serial link settings, control word watchdog and parameter write lock.
// Assumes synchronous inputs on mclk and an Avalon-MM master.
//
// What this block does
// - Node address register holds 0 to 63; master addresses that value.
// - Baud select spans 9.6 to 115.2 kbps; both ends use it.
// - Protocol bit at reset keeps fieldbus off, port free for accessory.
// - When enabled, time interval since last control word telegram.
// - Limit select: disabled, 30, 100, 1000 or 3000 ms.
// - Trip action on expiry raises loss of communication trip.
// - Coast action on expiry disables output at once, no trip.
// - Extended access only after stored access code entered.
// - Lock 0: every parameter readable and writable, but code reads and lock and code writes need extended access.
// - Lock 1: parameters readable; link, watchdog and code changes rejected.
`timescale 1ns/100ps
module slw_watchdog #(
    parameter logic [31:0] T30_CYC = slw_pkg::T30_CYC, // 30 ms count
    parameter logic [31:0] T100_CYC = slw_pkg::T100_CYC, // 100 ms count
    parameter logic [31:0] T1000_CYC = slw_pkg::T1000_CYC, // 1 s count
    parameter logic [31:0] T3000_CYC = slw_pkg::T3000_CYC // 3 s count
) (
    input wire logic mclk, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic [4:0] avs_address, // Byte address
    input wire logic avs_read, // Read strobe
    input wire logic avs_write, // Write strobe
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte enables
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic drive_enable, // Drive run enable
    output logic output_enable, // Drive output allowed
    output logic comm_trip, // Loss of communication trip
    output logic ext_access, // Extended parameters unlocked
    output logic protocol_en, // Fieldbus protocol active
    output logic [5:0] node_address, // Serial node address
    output logic [2:0] baud_sel, // Bit rate select
    output logic irq // Interrupt, level high
);
    // Zero counts would make the limit decode read as disabled
    if (T30_CYC == 32'h0000_0000 || T100_CYC == 32'h0000_0000 ||
        T1000_CYC == 32'h0000_0000 || T3000_CYC == 32'h0000_0000) begin : g_bad_cyc
        $error("slw_watchdog: timeout counts must be nonzero");
    end

    ////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, answer on the second edge
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic req;
    logic wr_acc;
    assign req = avs_read | avs_write;
    assign wr_acc = avs_write & ack_q;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register file
    logic [31:0] link_q, link_d;
    logic [31:0] wdog_q, wdog_d;
    logic [15:0] ctrlw_q, ctrlw_d;
    logic lock_q, lock_d;
    logic [15:0] code_q, code_d;
    logic ext_q, ext_d;
    logic [3:0] stat_q, stat_d;
    logic [3:0] mask_q, mask_d;
    logic [3:0] ev;
    logic teleg;
    logic [31:0] m;
    logic wr_locked;

    assign teleg = wr_acc && avs_address == slw_pkg::ADDR_CTRLW;

    always_comb begin
        link_d = link_q;
        wdog_d = wdog_q;
        ctrlw_d = ctrlw_q;
        lock_d = lock_q;
        code_d = code_q;
        ext_d = ext_q;
        mask_d = mask_q;
        wr_locked = 1'b0;
        m = 32'h0000_0000;
        if (wr_acc) begin
            unique case (avs_address)
                slw_pkg::ADDR_LINK: begin
                    m = merge(link_q, avs_writedata, avs_byteenable);
                    if (lock_q) begin
                        wr_locked = 1'b1;
                    end else if (m[slw_pkg::ADDR_LSB +: 6] <= 6'h3f &&
                        m[slw_pkg::BAUD_LSB +: 3] <= slw_pkg::BAUD_MAX) begin
                        link_d = m & 32'h0001_073f;
                    end
                end
                slw_pkg::ADDR_WDOG: begin
                    m = merge(wdog_q, avs_writedata, avs_byteenable);
                    if (lock_q) begin
                        wr_locked = 1'b1;
                    end else if (m[slw_pkg::WSEL_LSB +: 3] <= 3'h4) begin
                        wdog_d = m & 32'h0000_0017;
                    end
                end
                slw_pkg::ADDR_CTRLW: begin
                    ctrlw_d = avs_writedata[15:0];
                end
                slw_pkg::ADDR_LOCK: begin
                    if (ext_q) begin
                        lock_d = avs_writedata[0];
                    end else begin
                        wr_locked = 1'b1;
                    end
                end
                slw_pkg::ADDR_CODE: begin
                    if (ext_q && !lock_q) begin
                        code_d = avs_writedata[15:0];
                    end else begin
                        wr_locked = 1'b1;
                    end
                end
                slw_pkg::ADDR_ENTRY: begin
                    ext_d = avs_writedata[15:0] == code_q;
                end
                slw_pkg::ADDR_MASK: begin
                    mask_d = avs_writedata[3:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            link_q <= slw_pkg::LINK_RST;
            wdog_q <= slw_pkg::WDOG_RST;
            ctrlw_q <= 16'h0000;
            lock_q <= 1'b0;
            code_q <= slw_pkg::CODE_RST;
            ext_q <= 1'b0;
            mask_q <= 4'h0;
        end else begin
            link_q <= link_d;
            wdog_q <= wdog_d;
            ctrlw_q <= ctrlw_d;
            lock_q <= lock_d;
            code_q <= code_d;
            ext_q <= ext_d;
            mask_q <= mask_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Watchdog timer
    slw_pkg::slw_wd_e wd_q, wd_d;
    logic [31:0] cnt_q, cnt_d;
    logic [31:0] limit;
    logic trip_q, trip_d;
    logic coast_q, coast_d;
    logic expire;
    logic wd_on;

    always_comb begin
        unique case (wdog_q[slw_pkg::WSEL_LSB +: 3])
            3'h1: limit = T30_CYC;
            3'h2: limit = T100_CYC;
            3'h3: limit = T1000_CYC;
            3'h4: limit = T3000_CYC;
            default: limit = 32'h0000_0000;
        endcase
    end

    assign wd_on = limit != 32'h0000_0000 && drive_enable;

    always_comb begin
        wd_d = wd_q;
        cnt_d = cnt_q;
        expire = 1'b0;
        unique case (wd_q)
            slw_pkg::ST_IDLE: begin
                cnt_d = 32'h0000_0000;
                if (wd_on) begin
                    wd_d = slw_pkg::ST_RUN;
                end
            end
            slw_pkg::ST_RUN: begin
                if (!wd_on) begin
                    wd_d = slw_pkg::ST_IDLE;
                end else if (teleg) begin
                    cnt_d = 32'h0000_0000;
                end else if (cnt_q + 32'h0000_0001 >= limit) begin
                    expire = 1'b1;
                    wd_d = slw_pkg::ST_DONE;
                end else begin
                    cnt_d = cnt_q + 32'h0000_0001;
                end
            end
            slw_pkg::ST_DONE: begin
                if (!drive_enable) begin
                    wd_d = slw_pkg::ST_IDLE;
                end
            end
            default: wd_d = slw_pkg::ST_IDLE;
        endcase
    end

    always_comb begin
        trip_d = trip_q;
        coast_d = coast_q;
        if (expire && !wdog_q[slw_pkg::WACT_BIT]) begin
            trip_d = 1'b1;
        end
        if (expire && wdog_q[slw_pkg::WACT_BIT]) begin
            coast_d = 1'b1;
        end
        if (!drive_enable && wd_q == slw_pkg::ST_IDLE) begin
            coast_d = 1'b0;
        end
        if (!drive_enable && wr_acc && avs_address == slw_pkg::ADDR_STAT &&
            avs_writedata[slw_pkg::ST_TRIP]) begin
            trip_d = 1'b0;
        end
        if (expire && !wdog_q[slw_pkg::WACT_BIT]) begin
            trip_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status, interrupt and outputs
    assign ev = {teleg, wr_locked, expire & wdog_q[slw_pkg::WACT_BIT],
                 expire & ~wdog_q[slw_pkg::WACT_BIT]};

    always_comb begin
        stat_d = stat_q;
        if (wr_acc && avs_address == slw_pkg::ADDR_STAT) begin
            stat_d = stat_q & ~avs_writedata[3:0];
        end
        stat_d = stat_d | ev;
    end

    always_comb begin
        ack_d = req & ~ack_q;
        rdata_d = rdata_q; // Held until the next read answer
        if (avs_read && !ack_q) begin
            unique case (avs_address)
                slw_pkg::ADDR_LINK: rdata_d = link_q;
                slw_pkg::ADDR_WDOG: rdata_d = wdog_q;
                slw_pkg::ADDR_CTRLW: rdata_d = {16'h0000, ctrlw_q};
                slw_pkg::ADDR_LOCK: rdata_d = {31'h0000_0000, lock_q};
                slw_pkg::ADDR_CODE: rdata_d = ext_q ? {16'h0000, code_q} :
                                              32'h0000_0000;
                slw_pkg::ADDR_ENTRY: rdata_d = {31'h0000_0000, ext_q};
                slw_pkg::ADDR_STAT: rdata_d = {28'h000_0000, stat_q};
                slw_pkg::ADDR_MASK: rdata_d = {28'h000_0000, mask_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wd_q <= slw_pkg::ST_IDLE;
            cnt_q <= 32'h0000_0000;
            trip_q <= 1'b0;
            coast_q <= 1'b0;
            stat_q <= 4'h0;
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            avs_readdata <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
            output_enable <= 1'b0;
            comm_trip <= 1'b0;
            ext_access <= 1'b0;
            protocol_en <= 1'b0;
            node_address <= 6'h00;
            baud_sel <= 3'h0;
            irq <= 1'b0;
        end else begin
            wd_q <= wd_d;
            cnt_q <= cnt_d;
            trip_q <= trip_d;
            coast_q <= coast_d;
            stat_q <= stat_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            avs_readdata <= rdata_d;
            avs_waitrequest <= ~(req & ~ack_q);
            output_enable <= drive_enable & ~trip_d & ~coast_d;
            comm_trip <= trip_d;
            ext_access <= ext_d;
            protocol_en <= link_d[slw_pkg::PROT_BIT];
            node_address <= link_d[slw_pkg::ADDR_LSB +: 6];
            baud_sel <= link_d[slw_pkg::BAUD_LSB +: 3];
            irq <= |(stat_d & mask_d);
        end
    end
endmodule // slw_watchdog

// ===== test/slw_watchdog_properties.sv
// Port checker for the link watchdog block, bound onto slw_watchdog.
// Assumes one mclk domain with synchronous active-low rstn.
`timescale 1ns/100ps
module slw_chk (
    input wire logic mclk, // Clock
    input wire logic rstn, // Reset
    input wire logic avs_read, // Read strobe
    input wire logic avs_write, // Write strobe
    input wire logic [31:0] avs_readdata, // Read data
    input wire logic avs_waitrequest, // Stall
    input wire logic drive_enable, // Run request
    input wire logic output_enable, // Output allowed
    input wire logic comm_trip, // Trip
    input wire logic protocol_en, // Fieldbus on
    input wire logic [2:0] baud_sel, // Rate select
    input wire logic irq // Interrupt
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_wait_answer: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered on the next cycle");
    chk_read_hold: assert property (!$fell(avs_waitrequest) |->
        $stable(avs_readdata))
        else $error("read data moved outside an answer");
    chk_baud_range: assert property (baud_sel <= 3'h4)
        else $error("rate select out of range");
    chk_proto_default: assert property ($rose(rstn) |-> !protocol_en)
        else $error("fieldbus on straight after reset");
    chk_trip_sticky: assert property (comm_trip && drive_enable |=> comm_trip)
        else $error("trip cleared while drive enabled");
    chk_trip_idle: assert property (!drive_enable && !$past(drive_enable) &&
        !$past(drive_enable, 2) |-> !$rose(comm_trip))
        else $error("trip raised while drive not enabled");
    chk_trip_output: assert property ($rose(comm_trip) |->
        ##[0:2] !output_enable)
        else $error("output still on after trip");
    chk_oe_follow: assert property (!drive_enable && !$past(drive_enable) |->
        !output_enable)
        else $error("output on without drive enable");
    cov_trip: cover property ($rose(comm_trip));
    cov_coast: cover property (drive_enable && !comm_trip && $fell(output_enable));
    cov_irq: cover property ($rose(irq));
endmodule // slw_chk
bind slw_watchdog slw_chk chk_u (.mclk(mclk), .rstn(rstn),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .drive_enable(drive_enable),
    .output_enable(output_enable), .comm_trip(comm_trip),
    .protocol_en(protocol_en), .baud_sel(baud_sel), .irq(irq));

// ===== test/slw_master_model.sv
// Serial link master model: register accesses and control telegrams.
// Assumes the drive's Avalon-MM slave on the same mclk.
`timescale 1ns/100ps
module slw_master_model (
    input wire logic mclk, // Clock
    output logic [4:0] avs_address, // Address
    output logic avs_read, // Read strobe
    output logic avs_write, // Write strobe
    output logic [31:0] avs_writedata, // Write data
    output logic [3:0] avs_byteenable, // Lanes
    input wire logic [31:0] avs_readdata, // Read data
    input wire logic avs_waitrequest // Stall
);
    initial begin
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
    end
    // One access, held until waitrequest is seen low
    task automatic xfer(input logic wr, input logic [4:0] a,
                        input logic [31:0] d, input logic [3:0] be,
                        output logic [31:0] q);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        // Sampled at the rising edge, before the slave's own update
        do begin
            @(posedge mclk);
        end while (avs_waitrequest);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= ~d; // Idle data never repeats the last word
    endtask
    // Control word telegram: one write to the control word register
    task automatic telegram(input logic [15:0] cw);
        logic [31:0] q;
        xfer(1'b1, slw_pkg::ADDR_CTRLW, {16'h0000, cw}, 4'hf, q);
    endtask
endmodule // slw_master_model

// ===== test/slw_watchdog_tb.sv
// Self-checking bench for slw_watchdog, driven through the master model.
// Assumes short timeout parameters of 30, 100, 300 and 500 cycles.
`timescale 1ns/100ps
module slw_watchdog_tb;
    localparam int LIM [5] = '{0, 30, 100, 300, 500};
    logic mclk, rstn, drive_enable;
    logic [4:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, irq;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable;
    logic output_enable, comm_trip, ext_access, protocol_en;
    logic [5:0] node_address;
    logic [2:0] baud_sel;
    int errors = 0;
    int n_checks = 0;
    slw_master_model mst_u (.mclk(mclk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    slw_watchdog #(.T30_CYC(32'd30), .T100_CYC(32'd100), .T1000_CYC(32'd300),
        .T3000_CYC(32'd500)) dut_u (.mclk(mclk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .drive_enable(drive_enable),
        .output_enable(output_enable), .comm_trip(comm_trip),
        .ext_access(ext_access), .protocol_en(protocol_en),
        .node_address(node_address), .baud_sel(baud_sel), .irq(irq));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] be = 4'hf);
        logic [31:0] x;
        mst_u.xfer(1'b1, a, d, be, x);
    endtask
    task automatic rd(input logic [4:0] a);
        mst_u.xfer(1'b0, a, 32'h0000_0000, 4'hf, q);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic set_en(input logic v);
        @(posedge mclk);
        drive_enable <= v;
    endtask
    task automatic flags(input logic [31:0] e);
        check("trip", {31'h0, comm_trip}, e & 32'h1);
        check("output", {31'h0, output_enable}, (e >> 4) & 32'h1);
        check("irq", {31'h0, irq}, (e >> 8) & 32'h1);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        $display("watchdog expired");
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        drive_enable = 1'b0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        wait_cyc(1);
        check("proto", {31'h0, protocol_en}, 32'h0000_0000);
        rd(slw_pkg::ADDR_LINK);
        check("link rst", q, slw_pkg::LINK_RST);
        wr(slw_pkg::ADDR_LINK, 32'h0001_043f);
        wait_cyc(1);
        check("node", {26'h0, node_address}, 32'h0000_003f);
        check("baud", {29'h0, baud_sel}, 32'h0000_0004);
        check("proto on", {31'h0, protocol_en}, 32'h0000_0001);
        wr(slw_pkg::ADDR_LINK, 32'h0000_0500);
        rd(slw_pkg::ADDR_LINK);
        check("bad baud", q, 32'h0001_043f);
        $display("test link done");
        wr(slw_pkg::ADDR_MASK, 32'h0000_0001);
        for (int s = 1; s < 5; s++) begin
            wr(slw_pkg::ADDR_WDOG, 32'(s));
            set_en(1'b1);
            repeat (4) begin
                mst_u.telegram(16'h0001);
                wait_cyc(LIM[s] / 2);
            end
            mst_u.telegram(16'h0001);
            wait_cyc(LIM[s] - 6);
            flags(32'h0000_0010);
            wait_cyc(16);
            flags(32'h0000_0101);
            rd(slw_pkg::ADDR_STAT);
            check("stat trip", q & 32'h1, 32'h0000_0001);
            set_en(1'b0);
            wr(slw_pkg::ADDR_STAT, 32'h0000_000f);
            wait_cyc(1);
            flags(32'h0000_0000);
        end
        $display("test limits done");
        wr(slw_pkg::ADDR_WDOG, 32'h0000_0011);
        wr(slw_pkg::ADDR_WDOG, 32'h0000_0005);
        rd(slw_pkg::ADDR_WDOG);
        check("bad limit", q, 32'h0000_0011);
        set_en(1'b1);
        wait_cyc(40);
        flags(32'h0000_0000);
        rd(slw_pkg::ADDR_STAT);
        check("stat coast", q & 32'h3, 32'h0000_0002);
        set_en(1'b0);
        wr(slw_pkg::ADDR_STAT, 32'h0000_000f);
        wait_cyc(100);
        flags(32'h0000_0000);
        wr(slw_pkg::ADDR_WDOG, 32'h0000_0000);
        set_en(1'b1);
        wait_cyc(600);
        flags(32'h0000_0010);
        set_en(1'b0);
        $display("test coast and idle done");
        wr(slw_pkg::ADDR_ENTRY, 32'h0000_0064);
        wr(slw_pkg::ADDR_LOCK, 32'h0000_0001);
        check("ext bad", {31'h0, ext_access}, 32'h0000_0000);
        rd(slw_pkg::ADDR_LOCK);
        check("lock kept", q, 32'h0000_0000);
        wr(slw_pkg::ADDR_ENTRY, {16'h0000, slw_pkg::CODE_RST});
        wait_cyc(1);
        check("ext ok", {31'h0, ext_access}, 32'h0000_0001);
        rd(slw_pkg::ADDR_CODE);
        check("code", q, {16'h0000, slw_pkg::CODE_RST});
        wr(slw_pkg::ADDR_LOCK, 32'h0000_0001);
        wr(slw_pkg::ADDR_STAT, 32'h0000_000f);
        wr(slw_pkg::ADDR_LINK, 32'h0000_0205);
        rd(slw_pkg::ADDR_LINK);
        check("locked link", q, 32'h0001_043f);
        rd(slw_pkg::ADDR_STAT);
        check("stat rej", q & 32'h4, 32'h0000_0004);
        wr(slw_pkg::ADDR_LOCK, 32'h0000_0000);
        wr(slw_pkg::ADDR_LINK, 32'h0000_0205);
        rd(slw_pkg::ADDR_LINK);
        check("open link", q, 32'h0000_0205);
        check("node new", {26'h0, node_address}, 32'h0000_0005);
        wr(slw_pkg::ADDR_LINK, 32'h0000_0309, 4'h1);
        rd(slw_pkg::ADDR_LINK);
        check("lane link", q, 32'h0000_0209);
        $display("test lock done");
        give_verdict();
    end
endmodule // slw_watchdog_tb
